// File: vector_priority_program_map_tb_top.sv
// vector_priority_program_map_tb_top: self-checking bench for vpm_top.
// assumes vpm_pkg, the checker and the core model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t got %0h want %0h", $time, a, b); end end
module vector_priority_program_map_tb_top;
    logic        sys_clk_i, reset_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [5:0]  avs_address_i, irq_vector_o;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic [3:0]  avs_byteenable_i;
    logic [63:0] irq_src_i;
    logic        irq_req_o, flash_secure_i, security_state_o, fetch_en;
    logic [1:0]  irq_level_o, prog_region_o;
    logic [20:0] irq_fetch_addr_o, prog_addr_i, tb_addr;
    logic        dflash_core_rd_i, dflash_sec_rd_i, dflash_core_gnt_o, dflash_sec_gnt_o;
    logic [12:0] vb;
    logic        red_req, red_cgnt, red_sgnt;
    logic [1:0]  red_region;
    int          miscompares, check_count;

    vpm_top #(.REDUCED(1'h0)) uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .irq_src_i(irq_src_i), .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o),
        .irq_level_o(irq_level_o), .irq_fetch_addr_o(irq_fetch_addr_o), .prog_addr_i(prog_addr_i),
        .prog_region_o(prog_region_o), .flash_secure_i(flash_secure_i),
        .security_state_o(security_state_o), .dflash_core_rd_i(dflash_core_rd_i),
        .dflash_sec_rd_i(dflash_sec_rd_i), .dflash_core_gnt_o(dflash_core_gnt_o),
        .dflash_sec_gnt_o(dflash_sec_gnt_o));
    // reduced variant on the same stimulus: no can, program ram or data flash
    vpm_top #(.REDUCED(1'h1)) uut_red (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(),
        .avs_waitrequest_o(), .irq_src_i(irq_src_i), .irq_req_o(red_req), .irq_vector_o(),
        .irq_level_o(), .irq_fetch_addr_o(), .prog_addr_i(prog_addr_i), .prog_region_o(red_region),
        .flash_secure_i(flash_secure_i), .security_state_o(), .dflash_core_rd_i(dflash_core_rd_i),
        .dflash_sec_rd_i(dflash_sec_rd_i), .dflash_core_gnt_o(red_cgnt), .dflash_sec_gnt_o(red_sgnt));
    vpm_core_model core (.fetch_en_i(fetch_en), .irq_req_i(irq_req_o),
        .fetch_addr_i(irq_fetch_addr_o), .tb_addr_i(tb_addr), .prog_addr_o(prog_addr_i));

    // clock generation
    initial
    begin
        sys_clk_i = 1'h0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    // one avalon cycle, held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= wr;
        avs_read_i      <= !wr;
        @(posedge sys_clk_i);
        while (avs_waitrequest_o)
            @(posedge sys_clk_i);
        q = avs_readdata_o;
        avs_write_i <= 1'h0;
        avs_read_i  <= 1'h0;
        @(posedge sys_clk_i);
    endtask : bus

    // raise sources and compare the grant one edge after it is taken
    task automatic irq(input logic [63:0] s, input logic [5:0] v, input logic [1:0] l);
        irq_src_i <= s;
        repeat (2) @(posedge sys_clk_i);
        `CHK(irq_req_o, 1'h1)
        `CHK(irq_vector_o, v)
        `CHK(irq_level_o, l)
        `CHK(irq_fetch_addr_o, {vb, 8'h00} + {14'h0000, v, 1'h0})
    endtask : irq

    task automatic t_regs;
        logic [31:0] q;
        bus(1'h0, vpm_pkg::OFS_VBASE, 32'h0, q);
        `CHK(q, 32'h0000_0000)
        bus(1'h1, vpm_pkg::OFS_OPMODE, 32'h0000_0001, q);
        bus(1'h0, vpm_pkg::OFS_OPMODE, 32'h0, q);
        `CHK(q[1:0], 2'h3)
        `CHK(security_state_o, 1'h1)
        flash_secure_i <= 1'h0;
        bus(1'h0, vpm_pkg::OFS_OPMODE, 32'h0, q);
        `CHK(q[1], 1'h1)
        bus(1'h1, 6'h0C, 32'hFFFF_FFFF, q);
        bus(1'h0, 6'h0C, 32'h0, q);
        `CHK(q, 32'h0000_0000)
    endtask : t_regs

    task automatic t_map;
        logic [20:0] a [10] = '{21'h000000, 21'h003FFF, 21'h004000, 21'h020000, 21'h020FFF,
                                21'h021000, 21'h02F800, 21'h02FFFF, 21'h030000, 21'h1FFFFF};
        logic [1:0]  r [10] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h2, 2'h0, 2'h3, 2'h3, 2'h0, 2'h0};
        for (int i = 0; i < 10; i++)
        begin
            tb_addr <= a[i];
            repeat (2) @(posedge sys_clk_i);
            `CHK(prog_region_o, r[i])
            `CHK(red_region, (r[i] == 2'h3) ? 2'h0 : r[i])
        end
    endtask : t_map

    task automatic t_prio;
        logic [31:0] q;
        logic [5:0]  v [18] = '{6'h0E, 6'h0F, 6'h10, 6'h11, 6'h14, 6'h15, 6'h16, 6'h18, 6'h1A,
                                6'h1B, 6'h1C, 6'h1D, 6'h21, 6'h23, 6'h26, 6'h29, 6'h2A, 6'h2B};
        irq(64'h0000_0000_0000_0028, 6'h03, 2'h3);
        bus(1'h1, 6'h14, 32'h0000_8000, q);
        irq(64'h0000_0000_00C0_0000, 6'h17, 2'h2);
        bus(1'h1, vpm_pkg::OFS_PRIO0, 32'h0000_3000, q);
        bus(1'h0, vpm_pkg::OFS_PRIO0, 32'h0, q);
        `CHK(q, 32'h0000_3000)
        irq(64'h0000_0000_00C0_0040, 6'h06, 2'h3);
        irq_src_i <= 64'h0000_0000_0200_3183;
        repeat (2) @(posedge sys_clk_i);
        `CHK(irq_req_o, 1'h0)
        for (int i = 0; i < 18; i++)
        begin
            irq(64'h1 << v[i], v[i], (v[i] == 6'h0E) ? 2'h2 : (v[i] == 6'h0F) ? 2'h1 : 2'h0);
            `CHK(red_req, !(v[i] inside {[6'h1A:6'h1D]}))
        end
    endtask : t_prio

    task automatic t_vbase;
        logic [31:0] q;
        vb = 13'h0200;
        bus(1'h1, vpm_pkg::OFS_VBASE, {19'h00000, vb}, q);
        fetch_en <= 1'h1;
        irq(64'h0000_0000_0000_0004, 6'h02, 2'h3);
        @(posedge sys_clk_i);
        `CHK(prog_region_o, 2'h2)
        bus(1'h0, vpm_pkg::OFS_STATUS, 32'h0, q);
        `CHK(q, 32'h0000_0382)
        fetch_en  <= 1'h0;
        irq_src_i <= 64'h0;
    endtask : t_vbase

    task automatic t_dfl;
        for (int i = 0; i < 4; i++)
        begin
            {dflash_core_rd_i, dflash_sec_rd_i} <= i[1:0];
            @(posedge sys_clk_i);
            `CHK(dflash_core_gnt_o, i[1])
            `CHK(dflash_sec_gnt_o, i == 1)
            `CHK({red_cgnt, red_sgnt}, 2'h0)
        end
    endtask : t_dfl

    // main sequence
    initial
    begin
        {reset_n_i, avs_read_i, avs_write_i, fetch_en, dflash_core_rd_i, dflash_sec_rd_i} = 6'h00;
        {avs_address_i, avs_writedata_i, irq_src_i, tb_addr, vb} = '0;
        avs_byteenable_i = 4'hF;
        flash_secure_i   = 1'h1;
        repeat (3) @(posedge sys_clk_i);
        reset_n_i <= 1'h1;
        @(posedge sys_clk_i);
        t_regs();
        t_map();
        t_prio();
        t_vbase();
        t_dfl();
        test_done();
    end

    // watchdog against a hung handshake
    initial
    begin
        repeat (4000) @(posedge sys_clk_i);
        miscompares++;
        test_done();
    end
endmodule : vector_priority_program_map_tb_top

// File: vpm_core_model.sv
// vpm_core_model: core side that fetches vector entries on program space.
// assumes the bench selects when the core is in vector fetch mode.
`timescale 1ns/1ps
module vpm_core_model (
    input  wire logic        fetch_en_i,   // core fetches vectors
    input  wire logic        irq_req_i,    // request from controller
    input  wire logic [20:0] fetch_addr_i, // entry address
    input  wire logic [20:0] tb_addr_i,    // plain program address
    output logic      [20:0] prog_addr_o   // program bus address
);
    // fetch the two-word entry while fetch is enabled and a request stands, else plain fetch
    // the core only reads program space here; flash arrays are never written
    assign prog_addr_o = (fetch_en_i && irq_req_i) ? fetch_addr_i : tb_addr_i;
endmodule : vpm_core_model

// File: vpm_pkg.sv
// vpm_pkg: constants for the vector priority and program map block.
// assumes a 40 MHz system clock and a 32-bit avalon-mm register bus.
package vpm_pkg;
    localparam int NUM_VEC = 64;
    localparam int ADDR_W  = 21;                          // program word address width
    localparam int VBA_W   = 13;                          // vector base, upper address bits
    localparam int VBA_LSB = 8;                           // base is shifted by this much
    localparam logic [VBA_W-1:0] VBA_RESET = 13'h0000;

    // register byte offsets
    localparam logic [5:0] OFS_VBASE  = 6'h00;
    localparam logic [5:0] OFS_OPMODE = 6'h04;
    localparam logic [5:0] OFS_STATUS = 6'h08;
    localparam logic [5:0] OFS_PRIO0  = 6'h10;            // four words, 16 vectors each
    localparam logic [5:0] OFS_PRIO3  = 6'h1C;

    // operating mode fields
    localparam int OM_BOOT_SEL = 0;
    localparam int OM_SECURE   = 1;

    // vector classes
    localparam logic [63:0] VEC_VALID = 64'h0000_0FCE_3DF3_CEFC;
    localparam logic [63:0] VEC_FIXED = 64'h0000_0000_0001_C03C;
    localparam logic [63:0] VEC_DEBUG = 64'h0000_0000_0000_0EC0;
    localparam logic [63:0] VEC_CAN   = 64'h0000_0000_3C00_0000;

    // program space map
    localparam logic [20:0] PFLASH_LO  = 21'h000000;
    localparam logic [20:0] PFLASH_HI  = 21'h003FFF;
    localparam logic [20:0] BOOT_LO    = 21'h020000;
    localparam logic [20:0] BOOT_HI    = 21'h020FFF;
    localparam logic [20:0] BOOT_ENTRY = 21'h020000;
    localparam logic [20:0] WDOG_ENTRY = 21'h020002;
    localparam logic [20:0] PRAM_LO    = 21'h02F800;
    localparam logic [20:0] PRAM_HI    = 21'h02FFFF;

    typedef enum logic [1:0] {
        VPM_REG_RSVD,
        VPM_REG_PFLASH,
        VPM_REG_BOOT,
        VPM_REG_PRAM
    } vpm_region_e;
endpackage : vpm_pkg

// File: vpm_top.sv
// vpm_top: interrupt vector priority resolution and program space decode.
// assumes request, address and secure inputs come from logic on sys_clk_i.
// assumes the core takes a grant one clock after the request is seen.
//
// Notes on behaviour
// - pending higher priority level always wins over every lower level
// - within the winning level the smallest vector number is granted
// - fetch address is vector base plus the source's fixed table offset
// - core exceptions at vectors 2 to 5 run at fixed level 3
// - debug sources 6,7,9,10,11 take programmable level 1 to 3
// - flash module requests at vectors 22,23,24 take level 0 to 2
// - can controller requests at vectors 26 to 29 take level 0 to 2
// - low voltage 20, pll 21, external line a 17 take level 0 to 2
// - serial interfaces at 38 to 41, gpio at 33 to 35, level 0 to 2
// - second async serial uses vectors 42 and 43 at level 0 to 2
// - reset program map: flash, boot flash, program ram, rest reserved
// - boot select bit never changes the program map
// - security state bit holds the flash secured status taken on the first clock after reset
// - software writes to the security bit change nothing
// - data flash read goes through one bus only per cycle
// - reduced variant decodes data flash and program ram as absent
// - table entries are two words, offset is twice the vector number
// - base 0x0200 puts entries 0 and 1 over the reset addresses
`timescale 1ns/1ps
module vpm_top #(
    parameter bit REDUCED = 1'b0                           // 1: no data flash, no program ram
) (
    input  wire logic                        sys_clk_i,           // system clock
    input  wire logic                        reset_n_i,           // async reset, active low
    // avalon-mm slave
    input  wire logic [5:0]                  avs_address_i,       // byte address
    input  wire logic                        avs_read_i,          // read request
    input  wire logic                        avs_write_i,         // write request
    input  wire logic [31:0]                 avs_writedata_i,     // write data
    input  wire logic [3:0]                  avs_byteenable_i,    // byte lanes
    output logic      [31:0]                 avs_readdata_o,      // read data
    output logic                             avs_waitrequest_o,   // stall
    // interrupt sources and core side
    input  wire logic [vpm_pkg::NUM_VEC-1:0] irq_src_i,           // level requests by vector
    output logic                             irq_req_o,           // a request is pending
    output logic      [5:0]                  irq_vector_o,        // granted vector
    output logic      [1:0]                  irq_level_o,         // its level
    output logic      [vpm_pkg::ADDR_W-1:0]  irq_fetch_addr_o,    // vector entry address
    // program space decode
    input  wire logic [vpm_pkg::ADDR_W-1:0]  prog_addr_i,         // program word address
    output logic      [1:0]                  prog_region_o,       // decoded region
    // security and data flash read paths
    input  wire logic                        flash_secure_i,      // flash secured status
    output logic                             security_state_o,    // security state bit
    input  wire logic                        dflash_core_rd_i,    // core read bus request
    input  wire logic                        dflash_sec_rd_i,     // secondary bus request
    output logic                             dflash_core_gnt_o,   // core read bus granted
    output logic                             dflash_sec_gnt_o     // secondary bus granted
);

    // elaboration check
    if (vpm_pkg::NUM_VEC != 64)
    begin : g_chk
        $error("vpm_top serves exactly 64 vectors");
    end

    // fetch address is the base shifted up by the table's low bits
    if (vpm_pkg::VBA_W + vpm_pkg::VBA_LSB != vpm_pkg::ADDR_W)
    begin : g_chk_addr
        $error("vpm_top needs base and offset bits to fill the address");
    end

    // implemented vectors, can controller absent on the reduced variant
    localparam logic [63:0] IMPL = REDUCED ? (vpm_pkg::VEC_VALID & ~vpm_pkg::VEC_CAN) : vpm_pkg::VEC_VALID;

    // class of a vector: 0 none, 1 fixed, 2 level 1..3, 3 level 0..2
    function automatic logic [1:0] vec_class(input int v);
        if (!IMPL[v])
            return 2'd0;
        else if (vpm_pkg::VEC_FIXED[v])
            return 2'd1;
        else if (vpm_pkg::VEC_DEBUG[v])
            return 2'd2;
        else
            return 2'd3;
    endfunction : vec_class

    // effective rank: 0 not eligible, else level plus one
    function automatic logic [2:0] vec_rank(input int v, input logic [1:0] field);
        logic [2:0] r;
        r = 3'd0;
        case (vec_class(v))
            2'd1:
            begin
                if (v >= 2 && v <= 5)
                    r = 3'd4;
                else if (v == 14)
                    r = 3'd3;
                else if (v == 15)
                    r = 3'd2;
                else
                    r = 3'd1;
            end
            2'd2: r = (field == 2'd0) ? 3'd0 : {1'b0, field} + 3'd1;
            2'd3: r = (field == 2'd3) ? 3'd0 : {1'b0, field} + 3'd1;
            default: r = 3'd0;
        endcase
        return r;
    endfunction : vec_rank

    // word match on the register bus, the two byte-select bits are ignored
    function automatic logic reg_hit(input logic [5:0] a, input logic [5:0] ofs);
        return a[5:2] == ofs[5:2];
    endfunction : reg_hit

    // the four priority words, sixteen two-bit fields each
    function automatic logic prio_hit(input logic [5:0] a);
        return a[5:2] >= vpm_pkg::OFS_PRIO0[5:2] && a[5:2] <= vpm_pkg::OFS_PRIO3[5:2];
    endfunction : prio_hit

    // first vector held by the addressed priority word
    function automatic int prio_first(input logic [5:0] a);
        return int'(a[5:2] - vpm_pkg::OFS_PRIO0[5:2]) * 16;
    endfunction : prio_first

    // register state
    logic [vpm_pkg::VBA_W-1:0] vbase_reg, vbase_next;
    logic                      boot_sel_reg, boot_sel_next;
    logic                      secure_reg, secure_next;
    logic                      sec_taken_reg, sec_taken_next;
    // priority fields, one per vector, two bits each
    logic [1:0]                prio_reg [64];
    logic [1:0]                prio_next [64];
    logic                      done_reg, done_next;
    logic [31:0]               rdata_reg, rdata_next;
    logic                      req_reg, req_next;
    logic [5:0]                vec_reg, vec_next;
    logic [1:0]                lvl_reg, lvl_next;
    logic [20:0]               faddr_reg, faddr_next;
    logic [1:0]                region_reg, region_next;

    // arbitration signals
    logic [63:0] pend;
    logic [2:0]  best_rank;
    logic [5:0]  best_vec;
    logic        access;
    logic [3:0]  widx;

    assign access = avs_read_i | avs_write_i;
    assign widx   = avs_address_i[5:2];
    assign pend   = irq_src_i & IMPL;

    // one wait cycle, then answer
    assign avs_waitrequest_o = access & ~done_reg;

    // register writes, reads and bus handshake
    always_comb
    begin
        vbase_next     = vbase_reg;
        boot_sel_next  = boot_sel_reg;
        secure_next    = secure_reg;
        sec_taken_next = 1'b1;
        prio_next      = prio_reg;
        done_next      = access & ~done_reg;
        rdata_next     = rdata_reg;
        // the flash's secure status is taken once, on the first clock after reset; later software writes cannot move it
        if (!sec_taken_reg)
            secure_next = flash_secure_i;                  // caught on the first clock after reset
        if (avs_write_i && done_reg)
        begin
            if (reg_hit(avs_address_i, vpm_pkg::OFS_VBASE))
            begin
                if (avs_byteenable_i[0])
                    vbase_next[7:0] = avs_writedata_i[7:0];
                if (avs_byteenable_i[1])
                    vbase_next[12:8] = avs_writedata_i[12:8];
            end
            else if (reg_hit(avs_address_i, vpm_pkg::OFS_OPMODE) && avs_byteenable_i[0])
                boot_sel_next = avs_writedata_i[vpm_pkg::OM_BOOT_SEL];  // secure bit ignored
            else if (prio_hit(avs_address_i))
            begin
                // fields of fixed and reserved vectors stay zero, so no stray write enables them
                for (int k = 0; k < 16; k++)
                begin
                    if (avs_byteenable_i[k/4] && vec_class(prio_first(avs_address_i) + k) >= 2'd2)
                        prio_next[prio_first(avs_address_i) + k] = avs_writedata_i[2*k +: 2];
                end
            end
        end
        // read data is loaded on the wait cycle and stands until the next read
        if (avs_read_i && !done_reg)
        begin
            rdata_next = 32'h0000_0000;
            if (reg_hit(avs_address_i, vpm_pkg::OFS_VBASE))
                rdata_next[vpm_pkg::VBA_W-1:0] = vbase_reg;
            else if (reg_hit(avs_address_i, vpm_pkg::OFS_OPMODE))
            begin
                rdata_next[vpm_pkg::OM_BOOT_SEL] = boot_sel_reg;
                rdata_next[vpm_pkg::OM_SECURE]   = secure_reg;
            end
            else if (reg_hit(avs_address_i, vpm_pkg::OFS_STATUS))
                rdata_next[9:0] = {req_reg, lvl_reg, 1'b0, vec_reg};  // pending, level, vector
            else if (prio_hit(avs_address_i))
            begin
                for (int k = 0; k < 16; k++)
                    rdata_next[2*k +: 2] = prio_reg[prio_first(avs_address_i) + k];
            end
        end
    end

    // register file and bus handshake state
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            vbase_reg     <= vpm_pkg::VBA_RESET;
            boot_sel_reg  <= 1'b0;
            secure_reg    <= 1'b0;
            sec_taken_reg <= 1'b0;
            done_reg      <= 1'b0;
            rdata_reg     <= 32'h0000_0000;
            for (int i = 0; i < 64; i++)
                prio_reg[i] <= 2'd0;
        end
        else
        begin
            vbase_reg     <= vbase_next;
            boot_sel_reg  <= boot_sel_next;
            secure_reg    <= secure_next;
            sec_taken_reg <= sec_taken_next;
            done_reg      <= done_next;
            rdata_reg     <= rdata_next;
            prio_reg      <= prio_next;
        end
    end

    // priority search: higher rank wins, descending scan keeps lowest vector on ties
    // rank 0 means not eligible: a disabled field or an absent vector never competes
    always_comb
    begin
        best_rank = 3'd0;
        best_vec  = 6'd0;
        for (int v = 63; v >= 0; v--)
        begin
            if (pend[v] && vec_rank(v, prio_reg[v]) != 3'd0 && vec_rank(v, prio_reg[v]) >= best_rank)
            begin
                best_rank = vec_rank(v, prio_reg[v]);
                best_vec  = 6'(v);
            end
        end
    end

    // grant, fetch address and program space decode
    always_comb
    begin
        req_next    = best_rank != 3'd0;
        vec_next    = best_vec;
        lvl_next    = (best_rank == 3'd0) ? 2'd0 : 2'(best_rank - 3'd1);
        faddr_next  = {vbase_reg, 8'h00} + {14'h0000, best_vec, 1'b0};
        // the boot select bit is not an input of this decode, so it cannot move the map
        region_next = vpm_pkg::VPM_REG_RSVD;
        if (prog_addr_i <= vpm_pkg::PFLASH_HI)
            region_next = vpm_pkg::VPM_REG_PFLASH;
        else if (prog_addr_i >= vpm_pkg::BOOT_LO && prog_addr_i <= vpm_pkg::BOOT_HI)
            region_next = vpm_pkg::VPM_REG_BOOT;
        else if (!REDUCED && prog_addr_i >= vpm_pkg::PRAM_LO && prog_addr_i <= vpm_pkg::PRAM_HI)
            region_next = vpm_pkg::VPM_REG_PRAM;
    end

    // registered grant and region, one clock behind their inputs
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            req_reg    <= 1'b0;
            vec_reg    <= 6'd0;
            lvl_reg    <= 2'd0;
            faddr_reg  <= 21'h000000;
            region_reg <= vpm_pkg::VPM_REG_RSVD;
        end
        else
        begin
            req_reg    <= req_next;
            vec_reg    <= vec_next;
            lvl_reg    <= lvl_next;
            faddr_reg  <= faddr_next;
            region_reg <= region_next;
        end
    end

    // data flash read path: core bus first, never both
    // the reduced variant has no data flash, so neither bus is ever granted there
    assign dflash_core_gnt_o = !REDUCED && dflash_core_rd_i;
    assign dflash_sec_gnt_o  = !REDUCED && dflash_sec_rd_i && !dflash_core_rd_i;

    // outputs
    assign avs_readdata_o   = rdata_reg;
    assign irq_req_o        = req_reg;
    assign irq_vector_o     = vec_reg;
    assign irq_level_o      = lvl_reg;
    assign irq_fetch_addr_o = faddr_reg;
    assign prog_region_o    = region_reg;
    assign security_state_o = secure_reg;

endmodule : vpm_top

// File: vpm_top_assertions.sv
// vpm_top_assertions: port-level checks for vpm_top, bound below.
// assumes one clock domain with the async active-low reset.
`timescale 1ns/1ps
module vpm_top_assertions (
    input wire logic        sys_clk_i,         // system clock
    input wire logic        reset_n_i,         // async reset, active low
    input wire logic [63:0] irq_src_i,         // requests by vector
    input wire logic        irq_req_o,         // request pending
    input wire logic [5:0]  irq_vector_o,      // granted vector
    input wire logic [1:0]  irq_level_o,       // granted level
    input wire logic [20:0] irq_fetch_addr_o,  // entry address
    input wire logic [20:0] prog_addr_i,       // program address
    input wire logic [1:0]  prog_region_o,     // decoded region
    input wire logic        security_state_o,  // security bit
    input wire logic        dflash_core_gnt_o, // core bus grant
    input wire logic        dflash_sec_gnt_o   // secondary grant
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    // grant, level and fetch address against the requests, data flash buses, program map and security bit
    AST_FETCH_OFS: assert property (irq_req_o |-> irq_fetch_addr_o[7:0] == {1'h0, irq_vector_o, 1'h0})
        else $error("fetch offset is not twice the vector");
    AST_FIXED_LVL: assert property (irq_req_o && irq_vector_o inside {[2:5]} |-> irq_level_o == 2'h3)
        else $error("core exception not at level 3");
    AST_NO_RSVD: assert property (irq_req_o |-> vpm_pkg::VEC_VALID[irq_vector_o])
        else $error("reserved vector granted");
    AST_TOP_LVL: assert property (|irq_src_i[5:2] |=> irq_req_o && irq_level_o == 2'h3)
        else $error("level 3 request not served first");
    AST_LOW_VEC: assert property (irq_src_i[2] |=> irq_vector_o == 6'h02)
        else $error("lowest vector not granted");
    AST_ONE_BUS: assert property (!(dflash_core_gnt_o && dflash_sec_gnt_o))
        else $error("both data flash read buses granted");
    AST_FLASH_MAP: assert property (reset_n_i && prog_addr_i <= 21'h003FFF |=> prog_region_o == 2'h1)
        else $error("program flash not decoded");
    AST_SEC_HOLD: assert property ($past(reset_n_i, 2) |-> $stable(security_state_o))
        else $error("security bit changed after reset");
    // main scenarios reached
    COV_LVL3: cover property (irq_req_o && irq_level_o == 2'h3);
    COV_BOOT: cover property (prog_region_o == 2'h2);
    COV_PRAM: cover property (prog_region_o == 2'h3);
endmodule : vpm_top_assertions

bind vpm_top vpm_top_assertions chk (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .irq_src_i(irq_src_i),
    .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o), .irq_level_o(irq_level_o),
    .irq_fetch_addr_o(irq_fetch_addr_o), .prog_addr_i(prog_addr_i), .prog_region_o(prog_region_o),
    .security_state_o(security_state_o), .dflash_core_gnt_o(dflash_core_gnt_o),
    .dflash_sec_gnt_o(dflash_sec_gnt_o));
